// File: logic/fbr_cfg.svh
`ifndef FBR_CFG_SVH
`define FBR_CFG_SVH
`define FBR_CFG_RESET 16'hB7CF
`define FBR_B_MODE 15
`define FBR_B_LAT_HI 13
`define FBR_B_LAT_LO 11
`define FBR_B_WPOL 10
`define FBR_B_HOLD 9
`define FBR_B_WEARLY 8
`define FBR_B_EDGE 6
`define FBR_B_NOWRAP 3
`define FBR_B_LEN_HI 2
`define FBR_B_LEN_LO 0
`define FBR_LEN_4 3'h1
`define FBR_LEN_8 3'h2
`define FBR_LEN_16 3'h3
`define FBR_CMD_CFG_SETUP 8'h60
`define FBR_CMD_CFG_CONFIRM 8'h03
`define FBR_CMD_ID_ENTRY 8'h90
`define FBR_CMD_READ_ARRAY 8'hFF
`define FBR_CFG_READ_OFS 8'h05
`endif

// File: logic/fbr_pkg.sv
package fbr_pkg;
    typedef enum logic [2:0] {
        FBR_IDLE = 3'b001,
        FBR_LAT = 3'b010,
        FBR_DATA = 3'b100
    } fbr_state_t;
endpackage

// File: logic/fbr_seq_if.sv
`timescale 1ns/1ps
interface fbr_seq_if;
    logic load;
    logic step;
    logic [22:0] start_addr;
    logic no_wrap;
    logic [2:0] len_code;
    logic [22:0] addr;
    modport ctrl (output load, step, start_addr, no_wrap, len_code,
        input addr);
    modport seq (input load, step, start_addr, no_wrap, len_code,
        output addr);
endinterface

// File: logic/fbr_burst_addr.sv
`timescale 1ns/1ps
`include "fbr_cfg.svh"
module fbr_burst_addr (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    fbr_seq_if.seq sq
);
    // ==========================================
    // group mask from the length code
    function automatic logic [22:0] fbr_len_mask(input logic [2:0] code);
        unique case (code)
            `FBR_LEN_4: fbr_len_mask = 23'h000003;
            `FBR_LEN_8: fbr_len_mask = 23'h000007;
            `FBR_LEN_16: fbr_len_mask = 23'h00000F;
            default: fbr_len_mask = 23'h000000;
        endcase
    endfunction

    logic [22:0] addr_ff;
    logic [22:0] nxt_addr;
    logic [22:0] mask;
    logic [22:0] inc;

    // ==========================================
    // linear step, wrapped inside the aligned group when enabled
    always_comb begin
        mask = sq.no_wrap ? 23'h000000 : fbr_len_mask(sq.len_code);
        inc = addr_ff + 23'h000001;
        nxt_addr = (addr_ff & ~mask) | (inc & mask);
        if (mask == 23'h000000) begin
            nxt_addr = inc;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            addr_ff <= 23'h000000;
        end else if (clk_en) begin
            if (sq.load) begin
                addr_ff <= sq.start_addr;
            end else if (sq.step) begin
                addr_ff <= nxt_addr;
            end
        end
    end

    assign sq.addr = addr_ff;
endmodule // fbr_burst_addr

// File: logic/fbr_flash_burst_read_config.sv
`timescale 1ns/1ps
`include "fbr_cfg.svh"
module fbr_flash_burst_read_config (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic flash_clk_pin,
    input wire logic [22:0] addr_pin,
    input wire logic [15:0] dq_in,
    input wire logic ce_n_pin,
    input wire logic oe_n_pin,
    input wire logic we_n_pin,
    input wire logic address_latch_strobe_n,
    input wire logic [15:0] array_data,
    output logic [15:0] dq_out,
    output logic dq_oe_n,
    output logic wait_out,
    output logic [22:0] array_addr,
    output logic [15:0] cfg_word
);
    // ==========================================
    // pin synchronisers: 44 bits, two flops each
    localparam int PW = 44;
    logic [PW-1:0] pin_s1_ff;
    logic [PW-1:0] pin_s2_ff;
    logic clk_prev_ff;
    logic we_prev_ff;

    // pins only ever reach logic through the second stage
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pin_s1_ff <= {PW{1'b0}};
            pin_s2_ff <= {PW{1'b0}};
        end else if (clk_en) begin
            pin_s1_ff <= {flash_clk_pin, address_latch_strobe_n, we_n_pin,
                oe_n_pin, ce_n_pin, dq_in, addr_pin};
            pin_s2_ff <= pin_s1_ff;
        end
    end

    // ==========================================
    // edge history; write enable history resets high but the synced pin resets low, so only a high chip enable stops a write after reset
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            clk_prev_ff <= 1'b0;
            we_prev_ff <= 1'b1;
        end else if (clk_en) begin
            clk_prev_ff <= pin_s2_ff[43];
            we_prev_ff <= pin_s2_ff[41];
        end
    end

    logic [22:0] s_addr;
    logic [15:0] s_dq;
    logic s_ce_n;
    logic s_oe_n;
    logic s_we_n;
    logic s_latch_n;
    logic s_clk;
    assign s_addr = pin_s2_ff[22:0];
    assign s_dq = pin_s2_ff[38:23];
    assign s_ce_n = pin_s2_ff[39];
    assign s_oe_n = pin_s2_ff[40];
    assign s_we_n = pin_s2_ff[41];
    assign s_latch_n = pin_s2_ff[42];
    assign s_clk = pin_s2_ff[43];

    // ==========================================
    // configuration word and command decode
    logic [15:0] cfg_ff;
    logic cfg_pend_ff;
    logic id_mode_ff;
    logic we_done;
    logic [7:0] cmd;
    // edge finder shared by the write strobe and the link clock
    function automatic logic fbr_edge(input logic now, input logic prev,
        input logic rising);
        fbr_edge = rising ? (now && !prev) : (!now && prev);
    endfunction

    // a write is taken when write enable rises, so data has settled
    assign we_done = fbr_edge(s_we_n, we_prev_ff, 1'b1) && !s_ce_n;
    assign cmd = s_dq[7:0];

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cfg_ff <= `FBR_CFG_RESET;
            cfg_pend_ff <= 1'b0;
        end else if (clk_en && we_done) begin
            cfg_pend_ff <= (cmd == `FBR_CMD_CFG_SETUP);
            if (cfg_pend_ff && cmd == `FBR_CMD_CFG_CONFIRM) begin
                // reserved bits are stored but never steer anything
                cfg_ff <= s_addr[15:0];
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            id_mode_ff <= 1'b0;
        end else if (clk_en && we_done) begin
            if (cmd == `FBR_CMD_ID_ENTRY) begin
                id_mode_ff <= 1'b1;
            end else if (cmd == `FBR_CMD_READ_ARRAY) begin
                id_mode_ff <= 1'b0;
            end
        end
    end

    logic sync_mode;
    logic [2:0] lat_code;
    logic long_hold;
    logic wait_early;
    logic wait_high;
    logic act_edge;
    assign sync_mode = !cfg_ff[`FBR_B_MODE];
    assign lat_code = cfg_ff[`FBR_B_LAT_HI:`FBR_B_LAT_LO];
    assign long_hold = cfg_ff[`FBR_B_HOLD];
    assign wait_early = cfg_ff[`FBR_B_WEARLY];
    assign wait_high = cfg_ff[`FBR_B_WPOL];
    // bits 14 and 7 have a single setting each, so nothing decodes them
    // the link clock is sampled, so it must stay well below core_clk / 4
    assign act_edge = fbr_edge(s_clk, clk_prev_ff,
        cfg_ff[`FBR_B_EDGE]);

    // ==========================================
    // burst sequencer
    fbr_pkg::fbr_state_t state_ff;
    logic [2:0] lat_cnt_ff;
    logic hold_ff;
    logic [15:0] dq_ff;
    logic word_edge;
    fbr_seq_if sq ();

    fbr_burst_addr u_addr (
        .core_clk(core_clk),
        .rst(rst),
        .clk_en(clk_en),
        .sq(sq)
    );

    assign word_edge = act_edge && ((state_ff == fbr_pkg::FBR_LAT
        && lat_cnt_ff == 3'h1) || (state_ff == fbr_pkg::FBR_DATA
        && !hold_ff));
    assign sq.load = act_edge && state_ff == fbr_pkg::FBR_IDLE
        && sync_mode && !s_ce_n && !s_latch_n;
    assign sq.step = word_edge;
    assign sq.start_addr = s_addr;
    assign sq.no_wrap = cfg_ff[`FBR_B_NOWRAP];
    assign sq.len_code = cfg_ff[`FBR_B_LEN_HI:`FBR_B_LEN_LO];

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_ff <= fbr_pkg::FBR_IDLE;
            lat_cnt_ff <= 3'h0;
            hold_ff <= 1'b0;
        end else if (clk_en) begin
            if (s_ce_n || !sync_mode) begin
                state_ff <= fbr_pkg::FBR_IDLE;
            end else if (act_edge) begin
                unique case (state_ff)
                    fbr_pkg::FBR_IDLE: begin
                        if (!s_latch_n) begin
                            state_ff <= fbr_pkg::FBR_LAT;
                            lat_cnt_ff <= lat_code;
                        end
                    end
                    fbr_pkg::FBR_LAT: begin
                        if (lat_cnt_ff == 3'h1) begin
                            state_ff <= fbr_pkg::FBR_DATA;
                            hold_ff <= long_hold;
                        end else begin
                            lat_cnt_ff <= lat_cnt_ff - 3'h1;
                        end
                    end
                    fbr_pkg::FBR_DATA: begin
                        hold_ff <= hold_ff ? 1'b0 : long_hold;
                    end
                endcase
            end
        end
    end

    // ==========================================
    // output data: burst words on the chosen edge, async reads each cycle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dq_ff <= 16'h0000;
        end else if (clk_en) begin
            if (sync_mode) begin
                if (word_edge) begin
                    dq_ff <= array_data;
                end
            end else if (id_mode_ff) begin
                dq_ff <= (s_addr[7:0] == `FBR_CFG_READ_OFS) ? cfg_ff
                    : 16'h0000;
            end else begin
                dq_ff <= array_data;
            end
        end
    end

    // ==========================================
    // wait: asserted while data is not valid, optionally one clock early
    // outside latency the pin shows its inactive level, never floats
    logic not_valid;
    always_comb begin
        not_valid = 1'b0;
        unique case (state_ff)
            fbr_pkg::FBR_IDLE: begin
                not_valid = 1'b0;
            end
            fbr_pkg::FBR_LAT: begin
                // early mode drops wait on the last latency clock
                not_valid = !(wait_early && lat_cnt_ff == 3'h1);
            end
            fbr_pkg::FBR_DATA: begin
                // data state has no late words, so wait stays inactive
                not_valid = 1'b0;
            end
        endcase
    end
    assign wait_out = not_valid ? wait_high : !wait_high;
    assign dq_out = dq_ff;
    assign dq_oe_n = s_ce_n || s_oe_n;
    assign array_addr = sync_mode ? sq.addr : s_addr;
    assign cfg_word = cfg_ff;
endmodule // fbr_flash_burst_read_config

// File: verification/fbr_checker.sv
`timescale 1ns/1ps
`include "fbr_cfg.svh"
// ====================
// port checker
module fbr_checker (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic flash_clk_pin,
    input wire logic [22:0] addr_pin,
    input wire logic [15:0] dq_in,
    input wire logic ce_n_pin,
    input wire logic oe_n_pin,
    input wire logic we_n_pin,
    input wire logic address_latch_strobe_n,
    input wire logic [15:0] array_data,
    input wire logic [15:0] dq_out,
    input wire logic dq_oe_n,
    input wire logic wait_out,
    input wire logic [22:0] array_addr,
    input wire logic [15:0] cfg_word
);
    logic [1:0] age_ff;
    logic [22:0] grp;
    // pin syncs need three edges before past values are trustworthy
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) age_ff <= 2'h0;
        else if (age_ff != 2'h3) age_ff <= age_ff + 2'h1;
    end
    assign grp = {19'h0, cfg_word[1:0] == 2'h3, cfg_word[1:0] != 2'h1, 2'h3};
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // address moves after the latch strobe is long gone
    sequence s_step;
        !cfg_word[15] && $stable(cfg_word) && $changed(array_addr)
            && $past(address_latch_strobe_n, 7);
    endsequence
    property p_rst_dflt;
        $fell(rst) |-> cfg_word == `FBR_CFG_RESET;
    endproperty
    a_rst_dflt: assert property (p_rst_dflt)
        else $error("config word not default after reset");
    property p_cfg_wr;
        $changed(cfg_word) |-> $past(dq_in[7:0], 3) == `FBR_CMD_CFG_CONFIRM
            && cfg_word == $past(addr_pin[15:0], 3);
    endproperty
    a_cfg_wr: assert property (p_cfg_wr)
        else $error("config word changed without confirm write");
    property p_async_wait;
        cfg_word[15] |-> wait_out == !cfg_word[10];
    endproperty
    a_async_wait: assert property (p_async_wait)
        else $error("wait active in async mode");
    property p_idle_wait;
        ce_n_pin [*5] |-> wait_out == !cfg_word[10];
    endproperty
    a_idle_wait: assert property (p_idle_wait)
        else $error("wait active while deselected");
    property p_oe;
        age_ff == 2'h3 |-> dq_oe_n == ($past(ce_n_pin, 2) | $past(oe_n_pin, 2));
    endproperty
    a_oe: assert property (p_oe)
        else $error("data enable does not follow chip and output enable");
    property p_async_addr;
        age_ff == 2'h3 && cfg_word[15] && $stable(cfg_word)
            |-> array_addr == $past(addr_pin, 2);
    endproperty
    a_async_addr: assert property (p_async_addr)
        else $error("async array address not from pins");
    property p_wrap;
        s_step ##0 (!cfg_word[3] && !cfg_word[2] && cfg_word[1:0] != 2'h0)
            |-> ((array_addr ^ ($past(array_addr) + 23'h1)) & grp) == 23'h0
            && ((array_addr ^ $past(array_addr)) & ~grp) == 23'h0;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("wrapped burst step wrong");
    property p_linear;
        s_step ##0 (cfg_word[3] || cfg_word[2:0] == 3'h7)
            |-> array_addr == $past(array_addr) + 23'h1;
    endproperty
    a_linear: assert property (p_linear)
        else $error("linear burst step wrong");
endmodule // fbr_checker
bind fbr_flash_burst_read_config fbr_checker u_fbr_checker (
    .core_clk(core_clk), .rst(rst), .clk_en(clk_en),
    .flash_clk_pin(flash_clk_pin), .addr_pin(addr_pin), .dq_in(dq_in),
    .ce_n_pin(ce_n_pin), .oe_n_pin(oe_n_pin), .we_n_pin(we_n_pin),
    .address_latch_strobe_n(address_latch_strobe_n),
    .array_data(array_data), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .wait_out(wait_out), .array_addr(array_addr), .cfg_word(cfg_word));

// File: verification/fbr_host_model.sv
`timescale 1ns/1ps
// ====================
// host memory controller
module fbr_host_model (
    input wire logic core_clk,
    output logic flash_clk_pin,
    output logic [22:0] addr_pin,
    output logic [15:0] dq_in,
    output logic ce_n_pin,
    output logic oe_n_pin,
    output logic we_n_pin,
    output logic address_latch_strobe_n
);
    initial begin
        {flash_clk_pin, addr_pin, dq_in} = '0;
        {ce_n_pin, oe_n_pin, we_n_pin, address_latch_strobe_n} = 4'hF;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // pins held 7 cycles past the write edge so the sync has settled
    task automatic wr(input logic [7:0] cmd, input logic [22:0] a);
        @(posedge core_clk);
        {ce_n_pin, oe_n_pin} <= 2'h1;
        dq_in <= {8'h00, cmd};
        addr_pin <= a;
        we_n_pin <= 1'b0;
        cyc(2);
        we_n_pin <= 1'b1;
        cyc(7);
        dq_in <= ~dq_in;
    endtask
    task automatic rd(input logic [22:0] a);
        @(posedge core_clk);
        {ce_n_pin, oe_n_pin} <= 2'h0;
        addr_pin <= a;
        cyc(5);
    endtask
    // 320 ns link period is far below every latency limit
    task automatic tick();
        cyc(4);
        flash_clk_pin <= ~flash_clk_pin;
    endtask
    // strobe spans both edges so either clock edge setting latches
    task automatic burst(input logic [22:0] a);
        @(posedge core_clk);
        {ce_n_pin, address_latch_strobe_n} <= 2'h0;
        addr_pin <= a;
        tick();
        tick();
        cyc(4);
        address_latch_strobe_n <= 1'b1;
        addr_pin <= ~a;
    endtask
    task automatic stop();
        @(posedge core_clk);
        ce_n_pin <= 1'b1;
    endtask
endmodule // fbr_host_model

// File: verification/fbr_flash_burst_read_config_tb.sv
`timescale 1ns/1ps
`include "fbr_cfg.svh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_total++; \
    $display("[ERR] %0t got %0h exp %0h", $time, a, e); end end
// ====================
// testbench
module fbr_flash_burst_read_config_tb;
    logic core_clk, rst, snap, flash_clk_pin, ce_n_pin, oe_n_pin, we_n_pin;
    logic address_latch_strobe_n, dq_oe_n, wait_out;
    logic [22:0] addr_pin, array_addr, prev_addr, e23, exp_addr[$];
    logic [15:0] dq_in, array_data, dq_out, cfg_word, prev_cfg, e16;
    logic [15:0] exp_cfg[$], exp_dq[$];
    int err_total, total_checks, cycles;
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    assign array_data = array_addr[15:0] ^ 16'h5A5A;
    fbr_host_model u_fbr_host_model (.core_clk(core_clk),
        .flash_clk_pin(flash_clk_pin), .addr_pin(addr_pin), .dq_in(dq_in),
        .ce_n_pin(ce_n_pin), .oe_n_pin(oe_n_pin), .we_n_pin(we_n_pin),
        .address_latch_strobe_n(address_latch_strobe_n));
    fbr_flash_burst_read_config u_fbr_flash_burst_read_config (
        .core_clk(core_clk), .rst(rst), .clk_en(1'b1),
        .flash_clk_pin(flash_clk_pin), .addr_pin(addr_pin), .dq_in(dq_in),
        .ce_n_pin(ce_n_pin), .oe_n_pin(oe_n_pin), .we_n_pin(we_n_pin),
        .address_latch_strobe_n(address_latch_strobe_n),
        .array_data(array_data), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
        .wait_out(wait_out), .array_addr(array_addr), .cfg_word(cfg_word));
    task report_and_stop();
        if (err_total == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge core_clk) begin
        if (!rst && cfg_word !== prev_cfg) begin
            e16 = exp_cfg.size() ? exp_cfg.pop_front() : 16'hXXXX;
            `CHK(cfg_word, e16)
        end
        if (exp_addr.size() && array_addr !== prev_addr) begin
            if (exp_addr.size() < 20) begin
                `CHK(dq_out, prev_addr[15:0] ^ 16'h5A5A)
                `CHK(wait_out, !cfg_word[10])
            end
            e23 = exp_addr.pop_front();
            `CHK(array_addr, e23)
        end
        if (snap) begin
            e16 = exp_dq.pop_front();
            `CHK(dq_out, e16)
        end
        prev_cfg = cfg_word;
        prev_addr = array_addr;
        cycles++;
        if (cycles == 30000) begin
            err_total++;
            report_and_stop();
        end
    end
    task automatic rd_cfg(input logic [15:0] e, input logic [7:0] ofs);
        u_fbr_host_model.wr(`FBR_CMD_ID_ENTRY, 23'h0);
        exp_dq.push_back(e);
        u_fbr_host_model.rd({15'h0, ofs});
        snap <= 1'b1;
        @(posedge core_clk);
        snap <= 1'b0;
        u_fbr_host_model.wr(`FBR_CMD_READ_ARRAY, 23'h0);
    endtask
    task automatic set_cfg(input logic [15:0] c);
        u_fbr_host_model.wr(`FBR_CMD_CFG_SETUP, {7'h0, c});
        exp_cfg.push_back(c);
        u_fbr_host_model.wr(`FBR_CMD_CFG_CONFIRM, {7'h0, c});
    endtask
    initial begin
        logic [15:0] c;
        logic [22:0] s, m;
        logic [2:0] lat, len;
        int n;
        {rst, snap, cycles, err_total, total_checks} = '0;
        rst = 1'b1;
        void'($urandom(28614));
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        rd_cfg(`FBR_CFG_RESET, `FBR_CFG_READ_OFS);
        for (int i = 0; i < 8; i++) begin
            len = (i[2:1] == 2'h3) ? 3'h7 : {1'b0, i[2:1] + 2'h1};
            lat = 3'h2 + 3'($urandom % 5);
            c = {2'h0, lat, 3'($urandom), 1'b1, 1'($urandom), 2'h0, i[0], len};
            if (lat == 3'h2) c[9] = 1'b0;
            set_cfg(c);
            s = 23'($urandom);
            m = {19'h0, len == 3'h3, len != 3'h1, 2'h3};
            for (int k = 0; k < 20; k++)
                exp_addr.push_back((i[0] || len == 3'h7) ? s + 23'(k)
                    : (s & ~m) | ((s + 23'(k)) & m));
            u_fbr_host_model.burst(s);
            for (n = 0; exp_addr.size() != 0 && n < 300; n++)
                u_fbr_host_model.tick();
            u_fbr_host_model.stop();
            `CHK(exp_addr.size(), 0)
            exp_addr.delete();
        end
        c = {1'b1, 15'($urandom)} & 16'hFFCF;
        set_cfg(c);
        rd_cfg(c, `FBR_CFG_READ_OFS);
        rd_cfg(16'h0000, 8'h06);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        rd_cfg(`FBR_CFG_RESET, `FBR_CFG_READ_OFS);
        report_and_stop();
    end
endmodule // fbr_flash_burst_read_config_tb
